//--- src/sgd_gate_ctrl.sv
// Synchronous buck gate-drive sequencer with dead time, disables and register port
//
// Contract
// - Dead time runs from fall to complementary rise
// - Separate high and low dead-time settings
// - Dead-time count steps are 4 ns
// - Each side has its own delay bypass
// - Whole-driver disable holds both gates low
// - Side disable forces only that gate low
// - Strength bit selects 1A set, 2A clear
// - Period timer sets 100 kHz to 1.6 MHz
// - Pull-up bit connects positive sense pull-up
// - Pull-down bit connects negative sense pull-down
// - Undervoltage trip holds gates low until cleared
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module sgd_gate_ctrl
  import sgd_pkg::*;
(
  input  wire logic              clk_sys_in,         // System clock, 40 MHz
  input  wire logic              rst_in,             // Async reset, active high
  input  wire logic [REG_AW-1:0] addr_in,            // Register address
  input  wire logic [REG_DW-1:0] wr_data_in,         // Write data
  input  wire logic              wr_strobe_in,       // Write strobe
  input  wire logic              rd_strobe_in,       // Read strobe
  input  wire logic              uv_detect_in,       // Undervoltage comparator level
  output logic      [REG_DW-1:0] rd_data_out,        // Read data, cycle after strobe
  output logic                   high_side_gate_out, // High-side gate drive
  output logic                   low_side_gate_out,  // Low-side gate drive
  output logic                   phase_float_out,    // Switch node undriven by whole-driver disable only
  output logic                   high_drive_strength_sel_out, // 1A when high
  output logic                   sense_pull_up_en_out,        // Positive sense pull-up
  output logic                   sense_pull_down_en_out       // Negative sense pull-down
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sgd_state_s st;          // Registered state
  sgd_state_s next_st;     // Next state
  logic       kill_all;    // Both sides off
  logic       hi_ok;       // High side allowed
  logic       lo_ok;       // Low side allowed
  logic       pwm_req;     // Timer asks for high side
  logic       wr_sel;      // Write of any register
  logic       uv_clear;    // Firmware clears the flag

  // Drive and enable terms
  always_comb
  begin
    wr_sel   = wr_strobe_in;
    uv_clear = wr_sel && (addr_in == OFS_STATUS) && wr_data_in[BIT_UV_FLAG];
    kill_all = st.test.drv_dis || (st.prot.uv_trip && st.uv_flag);
    hi_ok    = !kill_all && !st.test.hi_dis;
    lo_ok    = !kill_all && !st.test.lo_dis;
    pwm_req  = st.test.run && (st.cnt < st.duty);
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    // Register writes
    if (wr_sel)
    begin
      case (addr_in)
        // Protection bits
        OFS_PROT_CTL:
        begin
          next_st.prot = sgd_prot_s'(wr_data_in[5:0]);
        end
        // Driver test bits
        OFS_TEST_CTL:
        begin
          next_st.test = sgd_test_s'(wr_data_in[3:0]);
        end
        OFS_DT_HIGH:
        begin
          next_st.dt_high = wr_data_in[DT_W-1:0];
        end
        OFS_DT_LOW:
        begin
          next_st.dt_low = wr_data_in[DT_W-1:0];
        end
        OFS_PERIOD:
        begin
          next_st.period = sgd_clamp_period(wr_data_in);
        end
        // High-side on time
        OFS_DUTY:
        begin
          next_st.duty = wr_data_in;
        end
        // Status and unmapped writes store nothing here
        default:
        begin
          next_st.duty = st.duty;
        end
      endcase
    end

    next_st.uv_flag = uv_detect_in || (st.uv_flag && !uv_clear);

    // period timer wraps at period
    // New period checked so a shorter write never strands the count
    if (!st.test.run)
    begin
      next_st.cnt = 16'h0000;
    end
    else if (st.cnt >= 16'(next_st.period - 16'h0001))
    begin
      next_st.cnt = 16'h0000;
    end
    else
    begin
      next_st.cnt = 16'(st.cnt + 16'h0001);
    end

    case (st.gate_st)
      // Low side conducting
      G_LOW_ON:
      begin
        if (pwm_req)
        begin
          if (st.prot.hdly_byp)
          begin
            next_st.gate_st = G_HIGH_ON;
          end
          else
          begin
            // high delay in 4 ns steps
            next_st.gate_st  = G_DEAD_HI;
            next_st.dead_cnt = sgd_dt_cycles(st.dt_high);
          end
        end
      end
      // Waiting before high rises
      G_DEAD_HI:
      begin
        if (!pwm_req)
        begin
          next_st.gate_st = G_LOW_ON;
        end
        else if (st.dead_cnt <= 4'h1)
        begin
          next_st.gate_st = G_HIGH_ON;
        end
        else
        begin
          next_st.dead_cnt = 4'(st.dead_cnt - 4'h1);
        end
      end
      // High side conducting
      G_HIGH_ON:
      begin
        if (!pwm_req)
        begin
          if (st.prot.ldly_byp)
          begin
            next_st.gate_st = G_LOW_ON;
          end
          else
          begin
            // low delay in 4 ns steps
            next_st.gate_st  = G_DEAD_LO;
            next_st.dead_cnt = sgd_dt_cycles(st.dt_low);
          end
        end
      end
      // Waiting before low rises
      G_DEAD_LO:
      begin
        if (pwm_req)
        begin
          next_st.gate_st = G_HIGH_ON;
        end
        else if (st.dead_cnt <= 4'h1)
        begin
          next_st.gate_st = G_LOW_ON;
        end
        else
        begin
          next_st.dead_cnt = 4'(st.dead_cnt - 4'h1);
        end
      end
      // Recover to safe state
      default:
      begin
        next_st.gate_st = G_LOW_ON;
      end
    endcase

    // one state, one gate at most
    next_st.hi_gate = (next_st.gate_st == G_HIGH_ON) && hi_ok;
    next_st.lo_gate = (next_st.gate_st == G_LOW_ON) && lo_ok;

    // Read answer, only in the cycle after the strobe
    next_st.rd_data = '0;
    if (rd_strobe_in)
    begin
      case (addr_in)
        // Control registers
        OFS_PROT_CTL: next_st.rd_data = REG_DW'(st.prot);
        OFS_TEST_CTL: next_st.rd_data = REG_DW'(st.test);
        OFS_DT_HIGH:  next_st.rd_data = REG_DW'(st.dt_high);
        OFS_DT_LOW:   next_st.rd_data = REG_DW'(st.dt_low);
        OFS_PERIOD:   next_st.rd_data = st.period;
        OFS_DUTY:     next_st.rd_data = st.duty;
        // Live status
        OFS_STATUS:
        begin
          next_st.rd_data[BIT_UV_FLAG] = st.uv_flag;
          next_st.rd_data[BIT_HI_GATE] = st.hi_gate;
          next_st.rd_data[BIT_LO_GATE] = st.lo_gate;
          next_st.rd_data[BIT_TRIPPED] = st.prot.uv_trip && st.uv_flag;
        end
        // Unmapped reads zero
        default: next_st.rd_data = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st          <= '0;
      st.period   <= RST_PERIOD;
      st.duty     <= RST_DUTY;
      st.dt_high  <= RST_DT;
      st.dt_low   <= RST_DT;
      st.gate_st  <= G_LOW_ON;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // undriven node follows disable
  always_comb
  begin
    rd_data_out                 = st.rd_data;
    high_side_gate_out          = st.hi_gate;
    low_side_gate_out           = st.lo_gate;
    phase_float_out             = st.test.drv_dis;
    high_drive_strength_sel_out = st.prot.drv_str;
    sense_pull_up_en_out        = st.prot.pull_up;
    sense_pull_down_en_out      = st.prot.pull_dn;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_no_overlap;
    @(posedge clk_sys_in) disable iff (rst_in)
    !(high_side_gate_out && low_side_gate_out);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both gates high");

  property p_drv_dis;
    @(posedge clk_sys_in) disable iff (rst_in)
    st.test.drv_dis |=> (!high_side_gate_out && !low_side_gate_out
                         && phase_float_out == st.test.drv_dis);
  endproperty
  a_drv_dis: assert property (p_drv_dis)
    else $error("gate high while driver disabled");

  property p_hi_dis;
    @(posedge clk_sys_in) disable iff (rst_in)
    (st.test.hi_dis && !kill_all && next_st.gate_st == G_LOW_ON && !st.test.lo_dis)
      |=> (!high_side_gate_out && low_side_gate_out);
  endproperty
  a_hi_dis: assert property (p_hi_dis)
    else $error("high disable did not act alone");

  property p_uv_trip;
    @(posedge clk_sys_in) disable iff (rst_in)
    (st.prot.uv_trip && st.uv_flag) |=> (!high_side_gate_out && !low_side_gate_out);
  endproperty
  a_uv_trip: assert property (p_uv_trip)
    else $error("gate high during undervoltage trip");

  property p_uv_set_wins;
    @(posedge clk_sys_in) disable iff (rst_in)
    uv_detect_in |=> st.uv_flag;
  endproperty
  a_uv_set_wins: assert property (p_uv_set_wins)
    else $error("undervoltage event lost");

  property p_dead_load;
    @(posedge clk_sys_in) disable iff (rst_in)
    (st.gate_st == G_HIGH_ON && !pwm_req && !st.prot.ldly_byp)
      |=> (st.gate_st == G_DEAD_LO && st.dead_cnt == sgd_dt_cycles($past(st.dt_low)));
  endproperty
  a_dead_load: assert property (p_dead_load)
    else $error("low dead time loaded wrong");

  property p_bypass;
    @(posedge clk_sys_in) disable iff (rst_in)
    (st.gate_st == G_LOW_ON && pwm_req && st.prot.hdly_byp) |=> st.gate_st == G_HIGH_ON;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("high bypass still delayed");

  property p_dead_end;
    @(posedge clk_sys_in) disable iff (rst_in)
    (st.gate_st == G_DEAD_HI && pwm_req && st.dead_cnt == 4'h1 && hi_ok)
      |=> (st.gate_st == G_HIGH_ON && $rose(high_side_gate_out));
  endproperty
  a_dead_end: assert property (p_dead_end)
    else $error("high did not rise after dead time");

  property p_dt_indep;
    @(posedge clk_sys_in) disable iff (rst_in)
    (wr_strobe_in && addr_in == OFS_DT_HIGH) |=> $stable(st.dt_low);
  endproperty
  a_dt_indep: assert property (p_dt_indep)
    else $error("high dead-time write changed low setting");

  property p_period_range;
    @(posedge clk_sys_in) disable iff (rst_in)
    (st.period >= PERIOD_MIN_CYC && st.period <= PERIOD_MAX_CYC && st.cnt < st.period);
  endproperty
  a_period_range: assert property (p_period_range)
    else $error("period timer out of range");

  property p_strength;
    @(posedge clk_sys_in) disable iff (rst_in)
    (wr_strobe_in && addr_in == OFS_PROT_CTL)
      |=> (high_drive_strength_sel_out == $past(wr_data_in[BIT_DRV_STR])
           && sense_pull_up_en_out == $past(wr_data_in[BIT_PULL_UP])
           && sense_pull_down_en_out == $past(wr_data_in[BIT_PULL_DN]));
  endproperty
  a_strength: assert property (p_strength)
    else $error("strength or pull bit not applied");

endmodule

//--- src/sgd_pkg.sv
// Constants, register map and state types of the gate-drive dead-time controller
package sgd_pkg;

  // ----------------------------------------------------------------
  // Bus and clock figures
  // ----------------------------------------------------------------
  localparam int          REG_AW          = 4;           // Register address width
  localparam int          REG_DW          = 16;          // Register data width
  localparam int          CLK_HZ          = 40_000_000;  // System clock rate
  localparam int          CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ; // Clock period in ns
  localparam int          DT_STEP_NS      = 4;           // Dead-time step per count
  localparam int          FSW_MIN_HZ      = 100_000;     // Lowest switching frequency
  localparam int          FSW_MAX_HZ      = 1_600_000;   // Highest switching frequency
  localparam logic [15:0] PERIOD_MIN_CYC  = 16'(CLK_HZ / FSW_MAX_HZ); // Shortest period
  localparam logic [15:0] PERIOD_MAX_CYC  = 16'(CLK_HZ / FSW_MIN_HZ); // Longest period

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_PROT_CTL    = 4'h0;  // protection_enable_ctl
  localparam logic [3:0] OFS_TEST_CTL    = 4'h1;  // driver_test_control
  localparam logic [3:0] OFS_DT_HIGH     = 4'h2;  // dead_time_config, high side
  localparam logic [3:0] OFS_DT_LOW      = 4'h3;  // dead_time_config, low side
  localparam logic [3:0] OFS_PERIOD      = 4'h4;  // period_timer period
  localparam logic [3:0] OFS_DUTY        = 4'h5;  // High-side on count
  localparam logic [3:0] OFS_STATUS      = 4'h6;  // Flags and gate levels

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_DRV_STR   = 0;  // high_drive_strength_sel
  localparam int BIT_LDLY_BYP  = 1;  // low_delay_bypass
  localparam int BIT_HDLY_BYP  = 2;  // high_delay_bypass
  localparam int BIT_PULL_UP   = 3;  // sense_pull_up_en
  localparam int BIT_PULL_DN   = 4;  // sense_pull_down_en
  localparam int BIT_UV_TRIP   = 5;  // uv_trip_enable
  localparam int BIT_DRV_DIS   = 0;  // driver_disable_all
  localparam int BIT_HI_DIS    = 1;  // high_side_disable
  localparam int BIT_LO_DIS    = 2;  // low_side_disable
  localparam int BIT_RUN       = 3;  // period_timer run
  localparam int BIT_UV_FLAG   = 0;  // undervoltage_flag, write one to clear
  localparam int BIT_HI_GATE   = 1;  // High gate level
  localparam int BIT_LO_GATE   = 2;  // Low gate level
  localparam int BIT_TRIPPED   = 3;  // Undervoltage trip active
  localparam int DT_W          = 6;  // Dead-time count field width
  localparam int DC_W          = 4;  // Dead-time cycle counter width

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_PERIOD = PERIOD_MAX_CYC;  // Slowest switching
  localparam logic [15:0] RST_DUTY   = 16'h0000;        // No high-side time
  localparam logic [5:0]  RST_DT     = 6'h00;           // No added delay

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {G_LOW_ON, G_DEAD_HI, G_HIGH_ON, G_DEAD_LO} sgd_gate_e;

  typedef struct packed {
    logic uv_trip;    // Undervoltage trip enable
    logic pull_dn;    // Negative sense pull-down
    logic pull_up;    // Positive sense pull-up
    logic hdly_byp;   // High-side delay bypass
    logic ldly_byp;   // Low-side delay bypass
    logic drv_str;    // High-side 1A when set
  } sgd_prot_s;

  typedef struct packed {
    logic run;        // Period timer running
    logic lo_dis;     // Low side forced low
    logic hi_dis;     // High side forced low
    logic drv_dis;    // Whole driver off
  } sgd_test_s;

  typedef struct packed {
    sgd_prot_s         prot;      // Protection control bits
    sgd_test_s         test;      // Driver test bits
    logic [DT_W-1:0]   dt_high;   // High-side dead-time count
    logic [DT_W-1:0]   dt_low;    // Low-side dead-time count
    logic [15:0]       period;    // Period in clock cycles
    logic [15:0]       duty;      // High-side on cycles
    logic [15:0]       cnt;       // Period timer count
    logic              uv_flag;   // Sticky undervoltage flag
    sgd_gate_e         gate_st;   // Gate sequencer state
    logic [DC_W-1:0]   dead_cnt;  // Remaining dead cycles
    logic              hi_gate;   // High gate drive
    logic              lo_gate;   // Low gate drive
    logic [REG_DW-1:0] rd_data;   // Read answer
  } sgd_state_s;

  // Dead-time count to clock cycles, rounded up, at least one
  function automatic logic [DC_W-1:0] sgd_dt_cycles(input logic [DT_W-1:0] count);
    int ns;
    int cyc;
    ns  = int'(count) * DT_STEP_NS;
    cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (cyc < 1)
    begin
      cyc = 1;
    end
    return DC_W'(cyc);
  endfunction

  // Keep period inside the legal frequency span
  function automatic logic [15:0] sgd_clamp_period(input logic [15:0] value);
    logic [15:0] res;
    res = value;
    if (value < PERIOD_MIN_CYC)
    begin
      res = PERIOD_MIN_CYC;
    end
    else if (value > PERIOD_MAX_CYC)
    begin
      res = PERIOD_MAX_CYC;
    end
    return res;
  endfunction

endpackage

//--- verification/sgd_fet_model.sv
// Far-side model of the two power switches: overlap and dead-gap watch
`timescale 1ns/10ps
module sgd_fet_model
(
  input  wire logic       clk_in,    // System clock
  input  wire logic       hi_in,     // High gate level
  input  wire logic       lo_in,     // Low gate level
  output logic            shoot_out, // Both switches on
  output logic [7:0]      gap_out    // Cycles of last dead gap
);
  logic [7:0] run_cnt = 8'h00;       // Cycles with both off

  assign shoot_out = hi_in & lo_in;

  // Gap length latched at each gate rise that ends a gap
  always_ff @(posedge clk_in)
  begin
    if (hi_in | lo_in)
    begin
      if (run_cnt != 8'h00)
      begin
        gap_out <= run_cnt;
      end
      run_cnt <= 8'h00;
    end
    else
    begin
      run_cnt <= run_cnt + 8'h01;
    end
  end
endmodule

//--- verification/sgd_gate_ctrl_tb.sv
// Self-checking bench of the gate-drive dead-time controller
`timescale 1ns/10ps
module sgd_gate_ctrl_tb
  import sgd_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              clk_sys = 1'b0; // 40 MHz clock
  logic              rst     = 1'b1; // Reset, high
  logic [REG_AW-1:0] addr    = '0;   // Bus address
  logic [REG_DW-1:0] wdat    = '0;   // Bus write data
  logic              wr      = 1'b0; // Write strobe
  logic              rd      = 1'b0; // Read strobe
  logic              uv      = 1'b0; // Undervoltage level
  logic [REG_DW-1:0] rdat;           // Read data
  logic              hi;             // High gate
  logic              lo;             // Low gate
  logic              flt;            // Switch node float
  logic              str;            // Strength select
  logic              pu;             // Pull-up enable
  logic              pd;             // Pull-down enable
  logic              shoot;          // Overlap seen by model
  logic [7:0]        gap;            // Last dead gap, cycles
  logic [REG_DW-1:0] got;            // Read result
  logic              prv;            // Other gate before rise
  logic              sh;             // High seen in window
  logic              sl;             // Low seen in window
  int                cyc;            // Cycles to a rise
  int                error_cnt = 0;  // Mismatches
  int                samples_checked = 0; // Comparisons

  // ----------------------------------------------------------------
  // Design and far side
  // ----------------------------------------------------------------
  sgd_gate_ctrl uut (.clk_sys_in(clk_sys), .rst_in(rst), .addr_in(addr),
    .wr_data_in(wdat), .wr_strobe_in(wr), .rd_strobe_in(rd), .uv_detect_in(uv),
    .rd_data_out(rdat), .high_side_gate_out(hi), .low_side_gate_out(lo),
    .phase_float_out(flt), .high_drive_strength_sel_out(str),
    .sense_pull_up_en_out(pu), .sense_pull_down_en_out(pd));
  sgd_fet_model fets (.clk_in(clk_sys), .hi_in(hi), .lo_in(lo),
    .shoot_out(shoot), .gap_out(gap));

  // Clock, 25 ns period
  initial
  begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  // One-cycle register write
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    wr   <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge clk_sys);
    wr   <= 1'b0;
  endtask

  // One-cycle read, data taken in the next cycle
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd   <= 1'b0;
    @(negedge clk_sys);
    d = rdat;
  endtask

  // Wait for a rise of one gate, bounded
  task automatic wait_rise(input bit side, output logic p, output int n);
    logic was;
    logic now;
    was = side ? hi : lo;
    for (n = 1; n < 1000; n++)
    begin
      p = side ? lo : hi;
      @(negedge clk_sys);
      now = side ? hi : lo;
      if (was === 1'b0 && now === 1'b1)
        return;
      was = now;
    end
    chk("gate rise timeout", 16'h0001, 16'h0000);
    end_of_test();
  endtask

  // Gate levels seen over n cycles
  task automatic watch(input int n, output logic h, output logic l);
    h = 1'b0;
    l = 1'b0;
    @(posedge clk_sys);
    repeat (n)
    begin
      @(negedge clk_sys);
      h = h | hi;
      l = l | lo;
    end
  endtask

  // Expected dead cycles for a count
  function automatic logic [15:0] dcyc(input int c);
    return (c * 4 + 24) / 25 < 1 ? 16'h0001 : 16'((c * 4 + 24) / 25);
  endfunction

  // Overlap watch every cycle
  always @(negedge clk_sys)
  begin
    if (!rst) chk("overlap", 16'h0000, {15'h0000, shoot === 1'b1});
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, read timing, unmapped place, period clamp
  task automatic sc_reset();
    chk("idle gates", 16'h0001, {14'h0000, hi, lo});
    rd_reg(OFS_PERIOD, got);
    chk("period rst", 16'h0190, got);
    @(negedge clk_sys);
    chk("rd after", 16'h0000, rdat);
    wr_reg(4'hF, 16'hFFFF);
    rd_reg(4'hF, got);
    chk("unmapped", 16'h0000, got);
    wr_reg(OFS_PERIOD, 16'h000A);
    rd_reg(OFS_PERIOD, got);
    chk("period min", 16'h0019, got);
    wr_reg(OFS_PERIOD, 16'h1000);
    rd_reg(OFS_PERIOD, got);
    chk("period max", 16'h0190, got);
  endtask

  // Separate dead times, step size, period, bypass per side
  task automatic sc_dead();
    wr_reg(OFS_PERIOD, 16'h0019);
    wr_reg(OFS_DUTY, 16'h000A);
    wr_reg(OFS_DT_HIGH, 16'h000A);
    wr_reg(OFS_DT_LOW, 16'h0014);
    wr_reg(OFS_TEST_CTL, 16'h0008);
    wait_rise(1, prv, cyc);
    wait_rise(1, prv, cyc);
    chk("period cyc", 16'h0019, 16'(cyc));
    @(negedge clk_sys);
    chk("gap high", dcyc(10), 16'(gap));
    wait_rise(0, prv, cyc);
    @(negedge clk_sys);
    chk("gap low", dcyc(20), 16'(gap));
    wr_reg(OFS_DT_HIGH, 16'h0000);
    wr_reg(OFS_DT_LOW, 16'h0028);
    wait_rise(1, prv, cyc);
    wait_rise(1, prv, cyc);
    @(negedge clk_sys);
    chk("gap zero", dcyc(0), 16'(gap));
    wr_reg(OFS_PROT_CTL, 16'h0004);
    wait_rise(1, prv, cyc);
    wait_rise(1, prv, cyc);
    chk("hi byp swap", 16'h0001, 16'(prv));
    wait_rise(0, prv, cyc);
    @(negedge clk_sys);
    chk("lo kept", dcyc(40), 16'(gap));
    wr_reg(OFS_PROT_CTL, 16'h0002);
    wait_rise(0, prv, cyc);
    wait_rise(0, prv, cyc);
    chk("lo byp swap", 16'h0001, 16'(prv));
    wait_rise(1, prv, cyc);
    @(negedge clk_sys);
    chk("hi gap back", dcyc(0), 16'(gap));
    wr_reg(OFS_PROT_CTL, 16'h0000);
  endtask

  // Whole and per-side disables
  task automatic sc_disable();
    wr_reg(OFS_TEST_CTL, 16'h0009);
    @(negedge clk_sys);
    chk("float", 16'h0001, 16'(flt));
    watch(60, sh, sl);
    chk("all off", 16'h0000, {14'h0000, sh, sl});
    wr_reg(OFS_TEST_CTL, 16'h000A);
    watch(60, sh, sl);
    chk("hi dis", 16'h0001, {14'h0000, sh, sl});
    wr_reg(OFS_TEST_CTL, 16'h000C);
    watch(60, sh, sl);
    chk("lo dis", 16'h0002, {14'h0000, sh, sl});
    wr_reg(OFS_TEST_CTL, 16'h0008);
    watch(60, sh, sl);
    chk("resume", 16'h0003, {14'h0000, sh, sl});
    chk("float off", 16'h0000, 16'(flt));
  endtask

  // Strength and sense pull bits
  task automatic sc_bits();
    wr_reg(OFS_PROT_CTL, 16'h0019);
    @(negedge clk_sys);
    chk("str pu pd", 16'h0007, {13'h0000, pd, pu, str});
    wr_reg(OFS_PROT_CTL, 16'h0000);
    @(negedge clk_sys);
    chk("bits off", 16'h0000, {13'h0000, pd, pu, str});
  endtask

  // Undervoltage trip until the flag is cleared
  task automatic sc_uv();
    wr_reg(OFS_PROT_CTL, 16'h0020);
    @(posedge clk_sys);
    uv <= 1'b1;
    @(posedge clk_sys);
    uv <= 1'b0;
    watch(60, sh, sl);
    chk("uv off", 16'h0000, {14'h0000, sh, sl});
    rd_reg(OFS_STATUS, got);
    chk("uv status", 16'h0009, got & 16'h000F);
    // Clear and event together, the event must win
    @(posedge clk_sys);
    uv <= 1'b1;
    wr_reg(OFS_STATUS, 16'h0001);
    uv <= 1'b0;
    rd_reg(OFS_STATUS, got);
    chk("uv set wins", 16'h0001, got & 16'h0001);
    wr_reg(OFS_STATUS, 16'h0001);
    watch(60, sh, sl);
    chk("uv clear", 16'h0003, {14'h0000, sh, sl});
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    @(negedge clk_sys);
    sc_reset();
    sc_dead();
    sc_disable();
    sc_bits();
    sc_uv();
    end_of_test();
  end
endmodule
